// ==== logic/rtc_core.sv ====
// real-time clock counters, alarm and event flags behind an apb slave
`timescale 1ns/10ps
module rtc_core (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire rtc_pkg::timebase_t tb,
  output logic                   irq_req
);
  rtc_pkg::rtc_state_t s_q, s_d;
  logic rd, wr, mapped, match_now;
  logic ev_hund, ev_tenth, ev_sec, ev_min, ev_hour, ev_per, ev_alrm;
  logic [rtc_pkg::NFLAGS-1:0] ev, clr_rd;

  // address decode, used only for the mapped check; read muxing decodes paddr itself
  function automatic logic is_mapped(input logic [7:0] a);
    return a <= rtc_pkg::ADDR_MODE && a[1:0] == 2'h0;
  endfunction

  // single-cycle answer: every access completes in its first access cycle
  assign pready  = 1'b1;
  assign rd      = psel && penable && !pwrite;
  assign wr      = psel && penable && pwrite;
  assign mapped  = is_mapped(paddr);
  assign pslverr = psel && penable && !mapped;
  assign prdata  = s_q.prdata;
  assign match_now = (s_q.hour == s_q.al_hour) && (s_q.min == s_q.al_min);

  // interrupt request: periodic follows rate select, others their enables
  assign irq_req = (s_q.flags[rtc_pkg::F_PER] &&
                    s_q.ctrl[rtc_pkg::C_RATE_HI:rtc_pkg::C_RATE_LO] != rtc_pkg::RATE_OFF)
                 || (s_q.flags[rtc_pkg::F_HOUR] && s_q.ctrl[rtc_pkg::C_HOUR_IRQ_ENABLE])
                 || (s_q.flags[rtc_pkg::F_MIN] && s_q.ctrl[rtc_pkg::C_MIE])
                 || (s_q.flags[rtc_pkg::F_SEC] && s_q.ctrl[rtc_pkg::C_SIE])
                 || (s_q.flags[rtc_pkg::F_ALRM] && s_q.ctrl[rtc_pkg::C_ALIE])
                 || (s_q.flags[rtc_pkg::F_HUND] && s_q.ctrl[rtc_pkg::C_HUIE]);

  always_comb begin
    s_d = s_q;
    // counter events
    ev_hund  = tb.tick_100hz && s_q.ctrl[rtc_pkg::C_HCE] && !s_q.mode[rtc_pkg::M_HOLD];
    ev_tenth = ev_hund && s_q.tenth_cnt == rtc_pkg::TENTH_DIV;
    ev_sec   = tb.tick_1hz && s_q.mode[rtc_pkg::M_TIME_EN];
    ev_min   = ev_sec && s_q.sec == rtc_pkg::SEC_MAX;
    ev_hour  = ev_min && s_q.min == rtc_pkg::MIN_MAX;
    ev_alrm  = match_now && !s_q.match_q;
    ev_per   = 1'b0;
    case (s_q.ctrl[rtc_pkg::C_RATE_HI:rtc_pkg::C_RATE_LO])
      rtc_pkg::RATE_1HZ: ev_per = tb.tick_1hz;
      rtc_pkg::RATE_2HZ: ev_per = tb.tick_100hz && s_q.per_cnt == rtc_pkg::TICKS_2HZ - 7'h1;
      // 4 Hz from a 25-tick count is even; the allowed jitter is unused
      rtc_pkg::RATE_4HZ: begin
        ev_per = tb.tick_100hz && s_q.per_cnt >= rtc_pkg::TICKS_4HZ - 7'h1;
      end
      default:           ev_per = 1'b0;
    endcase
    ev = '0;
    ev[rtc_pkg::F_PER]  = ev_per;
    ev[rtc_pkg::F_HOUR] = ev_hour;
    ev[rtc_pkg::F_MIN]  = ev_min;
    ev[rtc_pkg::F_SEC]  = ev_sec;
    ev[rtc_pkg::F_ALRM] = ev_alrm;
    ev[rtc_pkg::F_HUND] = ev_tenth;
    s_d.match_q = match_now;
    // free running periodic divider on the 100 Hz pulse
    if (tb.tick_100hz) begin
      s_d.per_cnt = (ev_per || s_q.per_cnt >= rtc_pkg::TICKS_2HZ - 7'h1) ? 7'h0
                    : s_q.per_cnt + 7'h1;
    end
    // hundredths counter and tenth divider
    if (s_q.mode[rtc_pkg::M_HOLD]) begin
      s_d.hund = 8'h00;
      s_d.tenth_cnt = 4'h0;
    end else if (ev_hund) begin
      s_d.hund = s_q.hund + 8'h01;
      s_d.tenth_cnt = ev_tenth ? 4'h0 : s_q.tenth_cnt + 4'h1;
    end
    // time of day cascade
    if (ev_sec) s_d.sec = ev_min ? 6'h00 : s_q.sec + 6'h01;
    if (ev_min) s_d.min = ev_hour ? 6'h00 : s_q.min + 6'h01;
    if (ev_hour) s_d.hour = (s_q.hour == rtc_pkg::HOUR_MAX) ? 5'h00 : s_q.hour + 5'h01;
    // clear sequences complete on reads of the partner registers
    clr_rd = '0;
    if (rd) begin
      clr_rd[rtc_pkg::F_PER]  = paddr == rtc_pkg::ADDR_CTRL;
      clr_rd[rtc_pkg::F_HOUR] = paddr == rtc_pkg::ADDR_HOUR;
      clr_rd[rtc_pkg::F_MIN]  = paddr == rtc_pkg::ADDR_MIN;
      clr_rd[rtc_pkg::F_SEC]  = paddr == rtc_pkg::ADDR_SEC;
      clr_rd[rtc_pkg::F_ALRM] = paddr == rtc_pkg::ADDR_ALMIN;
      clr_rd[rtc_pkg::F_HUND] = paddr == rtc_pkg::ADDR_HUND;
    end
    clr_rd = clr_rd & s_q.armed;
    // a flags read arms exactly what it returned; a flag set after its setup cycle
    // was never seen by software and must not be cleared by the partner read
    if (rd && paddr == rtc_pkg::ADDR_FLAGS) begin
      s_d.armed = s_q.armed | s_q.prdata[rtc_pkg::NFLAGS-1:0];
    end
    s_d.armed = s_d.armed & ~clr_rd;
    // set beats clear so a coincident event is never lost
    s_d.flags = (s_q.flags & ~clr_rd) | ev;
    // register writes; software time writes win over a same-cycle tick
    if (wr) begin
      case (paddr)
        rtc_pkg::ADDR_CTRL:   s_d.ctrl = pwdata[7:0];
        rtc_pkg::ADDR_SEC:    s_d.sec = pwdata[5:0];
        rtc_pkg::ADDR_MIN:    s_d.min = pwdata[5:0];
        rtc_pkg::ADDR_HOUR:   s_d.hour = pwdata[4:0];
        rtc_pkg::ADDR_ALMIN:  s_d.al_min = pwdata[5:0];
        rtc_pkg::ADDR_ALHOUR: s_d.al_hour = pwdata[4:0];
        rtc_pkg::ADDR_MODE:   s_d.mode = pwdata[1:0];
        default:              s_d.mode = s_d.mode;
      endcase
    end
    // read data registered at the setup cycle so it is valid in the access phase
    s_d.prdata = rtc_pkg::RESET_WORD;
    if (psel && !penable && !pwrite) begin
      case (paddr)
        rtc_pkg::ADDR_FLAGS:  s_d.prdata = {26'h0, s_q.flags};
        rtc_pkg::ADDR_CTRL:   s_d.prdata = {24'h0, s_q.ctrl};
        rtc_pkg::ADDR_HUND:   s_d.prdata = {24'h0, s_q.hund};
        rtc_pkg::ADDR_SEC:    s_d.prdata = {26'h0, s_q.sec};
        rtc_pkg::ADDR_MIN:    s_d.prdata = {26'h0, s_q.min};
        rtc_pkg::ADDR_HOUR:   s_d.prdata = {27'h0, s_q.hour};
        rtc_pkg::ADDR_ALMIN:  s_d.prdata = {26'h0, s_q.al_min};
        rtc_pkg::ADDR_ALHOUR: s_d.prdata = {27'h0, s_q.al_hour};
        rtc_pkg::ADDR_MODE:   s_d.prdata = {30'h0, s_q.mode};
        default:              s_d.prdata = rtc_pkg::RESET_WORD;
      endcase
    end
  end

  // whole state in one register; reset clears flags, counters and enables
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // counters and alarm values both reset to zero, so the match tracker starts
      // as matched; otherwise that equality would raise an alarm right after reset
      s_q <= '{match_q: 1'b1, default: '0};
    end else begin
      s_q <= s_d;
    end
  end

  // assertions
  property p_flags_reset;
    @(posedge pclk) $rose(presetn) |-> s_q.flags == '0;
  endproperty
  a_flags_reset: assert property (p_flags_reset)
    else $error("flags not clear after reset");
  property p_sec_wrap;
    @(posedge pclk) disable iff (!presetn)
      (ev_sec && s_q.sec == rtc_pkg::SEC_MAX && !wr) |=> s_q.sec == 6'h00;
  endproperty
  a_sec_wrap: assert property (p_sec_wrap) else $error("seconds did not wrap");
  property p_sec_flag;
    @(posedge pclk) disable iff (!presetn) ev_sec |=> s_q.flags[rtc_pkg::F_SEC];
  endproperty
  a_sec_flag: assert property (p_sec_flag) else $error("seconds flag not set");
  property p_hold;
    @(posedge pclk) disable iff (!presetn) s_q.mode[rtc_pkg::M_HOLD] |=> s_q.hund == 8'h00;
  endproperty
  a_hold: assert property (p_hold) else $error("hundredths not held at zero");
  property p_time_en;
    @(posedge pclk) disable iff (!presetn)
      (!s_q.mode[rtc_pkg::M_TIME_EN] && !wr) |=> $stable(s_q.sec);
  endproperty
  a_time_en: assert property (p_time_en) else $error("seconds moved while disabled");
  property p_no_hund_en;
    @(posedge pclk) disable iff (!presetn) !s_q.ctrl[rtc_pkg::C_HCE] |=> $stable(s_q.hund)
      || s_q.hund == 8'h00;
  endproperty
  a_no_hund_en: assert property (p_no_hund_en) else $error("hundredths ran ungated");
  property p_set_wins;
    @(posedge pclk) disable iff (!presetn) ev_min && clr_rd[rtc_pkg::F_MIN]
      |=> s_q.flags[rtc_pkg::F_MIN];
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("event lost to clear");
  property p_clear_min;
    @(posedge pclk) disable iff (!presetn) (clr_rd[rtc_pkg::F_MIN] && !ev_min)
      |=> !s_q.flags[rtc_pkg::F_MIN];
  endproperty
  a_clear_min: assert property (p_clear_min) else $error("minutes flag not cleared");
  property p_unarmed;
    @(posedge pclk) disable iff (!presetn) (rd && paddr == rtc_pkg::ADDR_SEC &&
      !s_q.armed[rtc_pkg::F_SEC] && s_q.flags[rtc_pkg::F_SEC]) |=> s_q.flags[rtc_pkg::F_SEC];
  endproperty
  a_unarmed: assert property (p_unarmed) else $error("flag cleared without status read");
  property p_irq_sec;
    @(posedge pclk) disable iff (!presetn)
      (s_q.flags[rtc_pkg::F_SEC] && s_q.ctrl[rtc_pkg::C_SIE]) |-> irq_req;
  endproperty
  a_irq_sec: assert property (p_irq_sec) else $error("missing seconds interrupt");
  c_hour_roll: cover property (@(posedge pclk) ev_hour && s_q.hour == rtc_pkg::HOUR_MAX);
  c_alarm: cover property (@(posedge pclk) ev_alrm);
  c_clear_seq: cover property (@(posedge pclk) |clr_rd);
  c_per_4hz: cover property (@(posedge pclk) ev_per &&
    s_q.ctrl[rtc_pkg::C_RATE_HI:rtc_pkg::C_RATE_LO] == rtc_pkg::RATE_4HZ);
  c_set_wins: cover property (@(posedge pclk) ev_min && clr_rd[rtc_pkg::F_MIN]);

  // one-hertz tick that ends a minute, shared by the rollover checks
  logic minute_end;
  assign minute_end = tb.tick_1hz && s_q.mode[rtc_pkg::M_TIME_EN] && s_q.sec == rtc_pkg::SEC_MAX;

  // periodic flag follows the selected rate and raises the request
  property p_per_1hz;
    @(posedge pclk) disable iff (!presetn)
      (s_q.ctrl[rtc_pkg::C_RATE_HI:rtc_pkg::C_RATE_LO] == rtc_pkg::RATE_1HZ && tb.tick_1hz)
      |=> s_q.flags[rtc_pkg::F_PER];
  endproperty
  a_per_1hz: assert property (p_per_1hz)
    else $error("periodic flag not set at 1 Hz");
  property p_per_off;
    @(posedge pclk) disable iff (!presetn)
      (s_q.ctrl[rtc_pkg::C_RATE_HI:rtc_pkg::C_RATE_LO] == rtc_pkg::RATE_OFF &&
       !s_q.flags[rtc_pkg::F_PER]) |=> !s_q.flags[rtc_pkg::F_PER];
  endproperty
  a_per_off: assert property (p_per_off)
    else $error("periodic flag set while rate is off");
  property p_irq_per;
    @(posedge pclk) disable iff (!presetn)
      (s_q.flags[rtc_pkg::F_PER] &&
       s_q.ctrl[rtc_pkg::C_RATE_HI:rtc_pkg::C_RATE_LO] != rtc_pkg::RATE_OFF) |-> irq_req;
  endproperty
  a_irq_per: assert property (p_irq_per)
    else $error("missing periodic interrupt");

  // cascade: flags and wraps at the end of a minute, of an hour and of a day
  property p_min_flag;
    @(posedge pclk) disable iff (!presetn) minute_end |=> s_q.flags[rtc_pkg::F_MIN];
  endproperty
  a_min_flag: assert property (p_min_flag)
    else $error("minutes flag not set");
  property p_min_wrap;
    @(posedge pclk) disable iff (!presetn)
      (minute_end && s_q.min == rtc_pkg::MIN_MAX && !wr) |=> s_q.min == 6'h00;
  endproperty
  a_min_wrap: assert property (p_min_wrap)
    else $error("minutes did not wrap");
  property p_hour_flag;
    @(posedge pclk) disable iff (!presetn)
      (minute_end && s_q.min == rtc_pkg::MIN_MAX) |=> s_q.flags[rtc_pkg::F_HOUR];
  endproperty
  a_hour_flag: assert property (p_hour_flag)
    else $error("hours flag not set");
  property p_hour_wrap;
    @(posedge pclk) disable iff (!presetn)
      (minute_end && s_q.min == rtc_pkg::MIN_MAX && s_q.hour == rtc_pkg::HOUR_MAX && !wr)
      |=> s_q.hour == 5'h00;
  endproperty
  a_hour_wrap: assert property (p_hour_wrap)
    else $error("hours did not wrap");

  // alarm: entering a match sets the flag; alarm values load from the bus
  property p_alarm;
    @(posedge pclk) disable iff (!presetn)
      (s_q.hour == s_q.al_hour && s_q.min == s_q.al_min && !s_q.match_q)
      |=> s_q.flags[rtc_pkg::F_ALRM];
  endproperty
  a_alarm: assert property (p_alarm)
    else $error("alarm flag not set on match");
  property p_al_min_wr;
    @(posedge pclk) disable iff (!presetn)
      (wr && paddr == rtc_pkg::ADDR_ALMIN) |=> s_q.al_min == $past(pwdata[5:0]);
  endproperty
  a_al_min_wr: assert property (p_al_min_wr)
    else $error("alarm minutes not written");
  property p_al_hour_wr;
    @(posedge pclk) disable iff (!presetn)
      (wr && paddr == rtc_pkg::ADDR_ALHOUR) |=> s_q.al_hour == $past(pwdata[4:0]);
  endproperty
  a_al_hour_wr: assert property (p_al_hour_wr)
    else $error("alarm hours not written");

  // hundredths: one step per gated pulse, tenth-second flag every tenth step
  property p_hund_step;
    @(posedge pclk) disable iff (!presetn)
      (tb.tick_100hz && s_q.ctrl[rtc_pkg::C_HCE] && !s_q.mode[rtc_pkg::M_HOLD])
      |=> s_q.hund == $past(s_q.hund) + 8'h01;
  endproperty
  a_hund_step: assert property (p_hund_step)
    else $error("hundredths did not step");
  property p_tenth;
    @(posedge pclk) disable iff (!presetn)
      (tb.tick_100hz && s_q.ctrl[rtc_pkg::C_HCE] && !s_q.mode[rtc_pkg::M_HOLD] &&
       s_q.tenth_cnt == rtc_pkg::TENTH_DIV) |=> s_q.flags[rtc_pkg::F_HUND];
  endproperty
  a_tenth: assert property (p_tenth)
    else $error("tenth-second flag not set");

  // armed partner reads clear their flag unless an event lands at once
  property p_clear_per;
    @(posedge pclk) disable iff (!presetn)
      (rd && paddr == rtc_pkg::ADDR_CTRL && s_q.armed[rtc_pkg::F_PER] && !ev_per)
      |=> !s_q.flags[rtc_pkg::F_PER];
  endproperty
  a_clear_per: assert property (p_clear_per)
    else $error("periodic flag not cleared");
  property p_clear_hour;
    @(posedge pclk) disable iff (!presetn)
      (rd && paddr == rtc_pkg::ADDR_HOUR && s_q.armed[rtc_pkg::F_HOUR] && !ev_hour)
      |=> !s_q.flags[rtc_pkg::F_HOUR];
  endproperty
  a_clear_hour: assert property (p_clear_hour)
    else $error("hours flag not cleared");
  property p_clear_sec;
    @(posedge pclk) disable iff (!presetn)
      (rd && paddr == rtc_pkg::ADDR_SEC && s_q.armed[rtc_pkg::F_SEC] && !ev_sec)
      |=> !s_q.flags[rtc_pkg::F_SEC];
  endproperty
  a_clear_sec: assert property (p_clear_sec)
    else $error("seconds flag not cleared");
  property p_clear_alarm;
    @(posedge pclk) disable iff (!presetn)
      (rd && paddr == rtc_pkg::ADDR_ALMIN && s_q.armed[rtc_pkg::F_ALRM] && !ev_alrm)
      |=> !s_q.flags[rtc_pkg::F_ALRM];
  endproperty
  a_clear_alarm: assert property (p_clear_alarm)
    else $error("alarm flag not cleared");
  property p_clear_tenth;
    @(posedge pclk) disable iff (!presetn)
      (rd && paddr == rtc_pkg::ADDR_HUND && s_q.armed[rtc_pkg::F_HUND] && !ev_tenth)
      |=> !s_q.flags[rtc_pkg::F_HUND];
  endproperty
  a_clear_tenth: assert property (p_clear_tenth)
    else $error("tenth-second flag not cleared");
endmodule

// ==== logic/rtc_pkg.sv ====
// package for the real-time clock status and time counters block
// Operation
// - read-only flags register holds six event flags, all cleared by reset
// - periodic flag sets when selected 1, 2 or 4 Hz interval elapses
// - at 4 Hz the periodic events may be uneven, averaging 4 Hz
// - periodic flag clears on flags read seeing it, then later control read
// - periodic interrupt requested whenever periodic rate select is nonzero
// - hours flag sets on hours rollover; interrupt when hour enable set
// - hours flag clears on flags read seeing it, then later hours read
// - minutes flag sets on minutes rollover; interrupt when minute enable set
// - minutes flag clears on flags read seeing it, then later minutes read
// - seconds flag sets every 1 Hz tick; interrupt when second enable set (code sets it only while time enable set)
// - seconds flag clears on flags read seeing it, then later seconds read
// - alarm flag sets on hours and minutes match; interrupt when alarm enabled
// - alarm flag clears on flags read seeing it, then later alarm minutes read
// - tenth-second flag sets at 10 Hz; interrupt when its enable set
// - tenth-second flag clears on flags read seeing it, then hundredths read
// - read-only 8-bit hundredths counter counts 100 Hz pulses, wraps after ff
// - writable 6-bit seconds counter counts 1 Hz, wraps at 59, reset clears
// - writable 6-bit minutes counter counts seconds wraps, wraps at 59
// - writable 5-bit hours counter counts minutes wraps, wraps at 23
// - read-write 6-bit alarm minutes value, reset clears, compared with minutes
// - read-write 5-bit alarm hours value, reset clears, compared with hours
// - rate select 00 off, 01 is 1 Hz, 10 is 2 Hz, 11 is 4 Hz
// - time counters advance only while time enable set; reset clears it
// - 100 Hz pulse reaches hundredths counter only while its clock enable set
// - while hold-clear is one the hundredths counter stays at 00
package rtc_pkg;
  // register byte addresses
  localparam logic [7:0] ADDR_FLAGS  = 8'h00;
  localparam logic [7:0] ADDR_CTRL   = 8'h04;
  localparam logic [7:0] ADDR_HUND   = 8'h08;
  localparam logic [7:0] ADDR_SEC    = 8'h0c;
  localparam logic [7:0] ADDR_MIN    = 8'h10;
  localparam logic [7:0] ADDR_HOUR   = 8'h14;
  localparam logic [7:0] ADDR_ALMIN  = 8'h18;
  localparam logic [7:0] ADDR_ALHOUR = 8'h1c;
  localparam logic [7:0] ADDR_MODE   = 8'h20;
  // flag bit positions
  localparam int F_HUND = 0;
  localparam int F_ALRM = 1;
  localparam int F_SEC  = 2;
  localparam int F_MIN  = 3;
  localparam int F_HOUR = 4;
  localparam int F_PER  = 5;
  localparam int NFLAGS = 6;
  // control bit positions
  localparam int C_RATE_LO = 0;
  localparam int C_RATE_HI = 1;
  localparam int C_ALIE    = 2;
  localparam int C_HCE     = 3;
  localparam int C_HUIE    = 4;
  localparam int C_SIE     = 5;
  localparam int C_MIE     = 6;
  localparam int C_HOUR_IRQ_ENABLE    = 7;
  // mode register bits
  localparam int M_TIME_EN = 0;
  localparam int M_HOLD    = 1;
  // rollover limits and divider counts
  localparam logic [5:0] SEC_MAX   = 6'h3b;
  localparam logic [5:0] MIN_MAX   = 6'h3b;
  localparam logic [4:0] HOUR_MAX  = 5'h17;
  localparam logic [7:0] HUND_MAX  = 8'hff;
  localparam logic [3:0] TENTH_DIV = 4'h9;
  localparam logic [1:0] RATE_OFF  = 2'h0;
  localparam logic [1:0] RATE_1HZ  = 2'h1;
  localparam logic [1:0] RATE_2HZ  = 2'h2;
  localparam logic [1:0] RATE_4HZ  = 2'h3;
  // 100 Hz ticks per periodic event
  localparam logic [6:0] TICKS_2HZ = 7'h32;
  localparam logic [6:0] TICKS_4HZ = 7'h19;
  localparam logic [31:0] RESET_WORD = 32'h0000_0000;
  typedef struct packed {
    logic [7:0] hund;
    logic [5:0] sec;
    logic [5:0] min;
    logic [4:0] hour;
    logic [5:0] al_min;
    logic [4:0] al_hour;
    logic [7:0] ctrl;
    logic [1:0] mode;
    logic [NFLAGS-1:0] flags;
    logic [NFLAGS-1:0] armed;
    logic [3:0] tenth_cnt;
    logic [6:0] per_cnt;
    logic       match_q;
    logic [31:0] prdata;
  } rtc_state_t;
  typedef struct packed {
    logic tick_1hz;
    logic tick_100hz;
  } timebase_t;
endpackage

// ==== sim/rtc_core_bench.sv ====
// self-checking bench for the rtc counters, alarm and event flags block
`timescale 1ns/10ps
module rtc_core_bench;
  logic               pclk;
  logic               presetn;
  logic               psel;
  logic               penable;
  logic               pwrite;
  logic [7:0]         paddr;
  logic [31:0]        pwdata;
  logic [31:0]        prdata;
  logic               pready;
  logic               pslverr;
  rtc_pkg::timebase_t tb;
  logic               irq_req;
  logic [31:0]        rv;
  logic               err;
  int                 n_fail;
  int                 cmp_count;
  logic [7:0]         clr_addr [5];
  logic [31:0]        clr_left [5];

  rtc_core rtc_core_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
                       .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
                       .pready(pready), .pslverr(pslverr), .tb(tb), .irq_req(irq_req));

  // 20 MHz bus clock
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one apb transfer; request held until pready is seen high, data taken at that edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rv  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rv, exp);
  endtask

  // one-cycle timebase pulses with a low cycle between, as the timebase makes them
  task automatic pulse(input logic hz1, input int n);
    repeat (n) begin
      @(posedge pclk);
      tb.tick_1hz   <= hz1;
      tb.tick_100hz <= ~hz1;
      @(posedge pclk);
      tb <= '0;
    end
  endtask

  task automatic test_done();
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // watchdog: the whole sequence needs well under 5000 cycles
  initial begin
    repeat (20000) @(posedge pclk);
    n_fail++;
    test_done();
  end

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    tb = '0;
    n_fail = 0;
    cmp_count = 0;
    clr_addr = '{rtc_pkg::ADDR_SEC, rtc_pkg::ADDR_MIN, rtc_pkg::ADDR_HOUR,
                 rtc_pkg::ADDR_ALMIN, rtc_pkg::ADDR_CTRL};
    clr_left = '{32'h3a, 32'h32, 32'h22, 32'h20, 32'h00};
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    // reset values of control, counters, alarm values and mode
    for (int i = 1; i < 9; i++) rd_chk(8'(i * 4), 32'h0);
    rd_chk(8'h24, 32'h0);
    chk({31'h0, err}, 32'h1);
    // set 23:59:59; writes to the read-only places must not land
    apb(1'b1, rtc_pkg::ADDR_SEC, 32'h3b);
    apb(1'b1, rtc_pkg::ADDR_MIN, 32'h3b);
    apb(1'b1, rtc_pkg::ADDR_HOUR, 32'h17);
    apb(1'b1, rtc_pkg::ADDR_FLAGS, 32'h3f);
    apb(1'b1, rtc_pkg::ADDR_HUND, 32'h55);
    rd_chk(rtc_pkg::ADDR_HOUR, 32'h17);
    rd_chk(rtc_pkg::ADDR_HUND, 32'h0);
    // read out and clear any alarm flag left pending before the rollover test
    apb(1'b0, rtc_pkg::ADDR_FLAGS, 32'h0);
    apb(1'b0, rtc_pkg::ADDR_ALMIN, 32'h0);
    rd_chk(rtc_pkg::ADDR_FLAGS, 32'h0);
    // one second tick rolls seconds, minutes and hours over and hits the alarm
    apb(1'b1, rtc_pkg::ADDR_CTRL, 32'h1);
    apb(1'b1, rtc_pkg::ADDR_MODE, 32'h1);
    pulse(1'b1, 1);
    rd_chk(rtc_pkg::ADDR_SEC, 32'h0);
    rd_chk(rtc_pkg::ADDR_MIN, 32'h0);
    rd_chk(rtc_pkg::ADDR_HOUR, 32'h0);
    rd_chk(rtc_pkg::ADDR_FLAGS, 32'h3e);
    chk({31'h0, irq_req}, 32'h1);
    // each partner read clears only its own armed flag
    for (int i = 0; i < 5; i++) begin
      apb(1'b0, clr_addr[i], 32'h0);
      rd_chk(rtc_pkg::ADDR_FLAGS, clr_left[i]);
    end
    chk({31'h0, irq_req}, 32'h0);
    // a partner read without a prior flags read leaves the flag alone
    pulse(1'b1, 1);
    apb(1'b0, rtc_pkg::ADDR_SEC, 32'h0);
    rd_chk(rtc_pkg::ADDR_FLAGS, 32'h24);
    apb(1'b0, rtc_pkg::ADDR_SEC, 32'h0);
    apb(1'b0, rtc_pkg::ADDR_CTRL, 32'h0);
    // time counters frozen and periodic events off
    apb(1'b1, rtc_pkg::ADDR_MODE, 32'h0);
    apb(1'b1, rtc_pkg::ADDR_CTRL, 32'h0);
    pulse(1'b1, 1);
    rd_chk(rtc_pkg::ADDR_SEC, 32'h1);
    apb(1'b0, rtc_pkg::ADDR_FLAGS, 32'h0);
    chk({31'h0, rv[5]}, 32'h0);
    // hundredths count, tenth-second flag and wrap after ff
    apb(1'b1, rtc_pkg::ADDR_CTRL, 32'h8);
    pulse(1'b0, 10);
    rd_chk(rtc_pkg::ADDR_HUND, 32'ha);
    apb(1'b0, rtc_pkg::ADDR_FLAGS, 32'h0);
    chk({31'h0, rv[0]}, 32'h1);
    pulse(1'b0, 246);
    rd_chk(rtc_pkg::ADDR_HUND, 32'h0);
    // gated clock: pulses are lost while the enable is low
    apb(1'b1, rtc_pkg::ADDR_CTRL, 32'h10);
    pulse(1'b0, 3);
    rd_chk(rtc_pkg::ADDR_HUND, 32'h0);
    apb(1'b1, rtc_pkg::ADDR_CTRL, 32'h18);
    pulse(1'b0, 10);
    rd_chk(rtc_pkg::ADDR_HUND, 32'ha);
    chk({31'h0, irq_req}, 32'h1);
    apb(1'b1, rtc_pkg::ADDR_CTRL, 32'h8);
    @(posedge pclk); // the enable write lands at the edge the task returns on
    chk({31'h0, irq_req}, 32'h0);
    // hold-clear pins the count at zero until released
    apb(1'b1, rtc_pkg::ADDR_MODE, 32'h2);
    pulse(1'b0, 3);
    rd_chk(rtc_pkg::ADDR_HUND, 32'h0);
    apb(1'b1, rtc_pkg::ADDR_MODE, 32'h0);
    pulse(1'b0, 2);
    rd_chk(rtc_pkg::ADDR_HUND, 32'h2);
    // 2 Hz and 4 Hz periodic events from the 100 Hz pulses
    for (int r = 2; r < 4; r++) begin
      apb(1'b1, rtc_pkg::ADDR_CTRL, 32'(r));
      apb(1'b0, rtc_pkg::ADDR_FLAGS, 32'h0);
      apb(1'b0, rtc_pkg::ADDR_CTRL, 32'h0);
      apb(1'b0, rtc_pkg::ADDR_FLAGS, 32'h0);
      chk({31'h0, rv[5]}, 32'h0);
      pulse(1'b0, (r == 2) ? 50 : 25);
      apb(1'b0, rtc_pkg::ADDR_FLAGS, 32'h0);
      chk({31'h0, rv[5]}, 32'h1);
    end
    // alarm at a set time; a minutes rollover meets an armed minutes read
    apb(1'b1, rtc_pkg::ADDR_ALHOUR, 32'h05);
    apb(1'b1, rtc_pkg::ADDR_ALMIN, 32'h2a);
    rd_chk(rtc_pkg::ADDR_ALHOUR, 32'h05);
    rd_chk(rtc_pkg::ADDR_ALMIN, 32'h2a);
    apb(1'b1, rtc_pkg::ADDR_HOUR, 32'h05);
    apb(1'b1, rtc_pkg::ADDR_MIN, 32'h28);
    apb(1'b1, rtc_pkg::ADDR_SEC, 32'h3b);
    apb(1'b1, rtc_pkg::ADDR_MODE, 32'h1);
    pulse(1'b1, 1);
    apb(1'b0, rtc_pkg::ADDR_FLAGS, 32'h0);
    chk({31'h0, rv[1]}, 32'h0);
    apb(1'b1, rtc_pkg::ADDR_SEC, 32'h3b);
    // the tick stands at the access edge of the minutes read
    fork
      apb(1'b0, rtc_pkg::ADDR_MIN, 32'h0);
      begin
        repeat (2) @(posedge pclk);
        tb.tick_1hz <= 1'b1;
        @(posedge pclk);
        tb <= '0;
      end
    join
    chk(rv, 32'h29);
    apb(1'b0, rtc_pkg::ADDR_FLAGS, 32'h0);
    chk({30'h0, rv[3], rv[1]}, 32'h3);
    // a reset in mid-run clears the flags, the request and the time
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd_chk(rtc_pkg::ADDR_FLAGS, 32'h0);
    rd_chk(rtc_pkg::ADDR_MIN, 32'h0);
    chk({31'h0, irq_req}, 32'h0);
    test_done();
  end
endmodule
